// ==== hw/vcl_loader_cfg.svh ====
`ifndef VCL_LOADER_CFG_SVH
`define VCL_LOADER_CFG_SVH

// Device clock rate and serial clock figures
`define VCL_CLK_MHZ 16'h00C8
`define VCL_SCLK_OUT_MHZ 16'h0001
`define VCL_SCLK_HALF_CLKS 16'h0028

// Sequencing delays in device clocks
`define VCL_PROM_ENABLE_N_DLY_CLKS 16'h0004
`define VCL_SENSE_DLY_CLKS 16'h0028
`define VCL_STROBE_CLKS 16'h0028
`define VCL_VEC_CLKS 16'h0008

// Configuration stream length in bits
`define VCL_STREAM_BITS 9'h17C

// Interrupt level used while loading
`define VCL_INIT_IRQ_LEVEL 3'h2

// Region patterns for later configuration writes
`define VCL_REGION_CSR_MASK 4'h3
`define VCL_REGION_A16_MASK 4'h1

`endif

// ==== hw/vcl_loader_pkg.sv ====
package vcl_loader_pkg;

	// Sequencer states
	typedef enum logic [4:0] {
		VCL_ST_RESET,
		VCL_ST_SENSE,
		VCL_ST_BUS_WAIT,
		VCL_ST_BUS_IRQ,
		VCL_ST_BUS_VEC,
		VCL_ST_BUS_FIRST,
		VCL_ST_BUS_FSTB,
		VCL_ST_BUS_BITS,
		VCL_ST_BUS_CMP,
		VCL_ST_BUS_CSTB,
		VCL_ST_BUS_MASK,
		VCL_ST_BUS_MSTB,
		VCL_ST_SER_SHIFT,
		VCL_ST_LOC_LOAD,
		VCL_ST_DONE
	} vcl_state_t;

	// Address modifier class of a bus cycle
	typedef enum logic [1:0] {
		VCL_AM_OTHER,
		VCL_AM_A16,
		VCL_AM_CSR
	} vcl_am_t;

endpackage

// ==== hw/vcl_sync.sv ====
`timescale 1ns/1ps

// Two-stage level synchroniser, one per bit
module vcl_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // Destination clock
	input wire logic [W-1:0] d_i, // Asynchronous levels
	output logic [W-1:0] q_o // Synchronised levels
);

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic meta;
			logic stable;
			// First stage feeds only the second
			always_ff @(posedge clk_i) begin
				meta <= d_i[gi];
				stable <= meta;
			end
			assign q_o[gi] = stable;
		end
	endgenerate

endmodule

// ==== hw/vcl_loader.sv ====
`timescale 1ns/1ps
`include "vcl_loader_cfg.svh"

module vcl_loader
	import vcl_loader_pkg::*;
(
	input wire logic ref_clk_i, // Device clock
	input wire logic nrst_i, // Sync reset, active low
	input wire logic sys_reset_n_i, // Backplane reset pin
	input wire logic serial_cfg_bit_in_i, // Serial data pin
	input wire logic sclk_in_i, // Serial clock pin level
	output logic sclk_out_o, // Serial clock driven value
	output logic sclk_oe_n_o, // Low while driving clock pin
	output logic prom_enable_n_o, // Serial PROM enable
	output logic irq_n_o, // Interrupt request
	output logic [2:0] irq_level_o, // Active interrupt level
	input wire logic [2:0] irq_level_cfg_i, // Programmed level
	output logic init_vector_enable_o, // Status ID enable
	output logic local_data_enable_n_o, // Local latch enable
	output logic compare_mask_select_o, // High compare, low mask
	output logic load_strobe_o, // Register load strobe
	output logic multi_write_n_o, // Held high while loading
	output logic block_xfer_n_o, // Held high while loading
	output logic cfg_bit_o, // Latest stream bit
	output logic cfg_bit_valid_o, // Pulse per stream bit
	output logic am_drive_en_o, // Modifier output allowed
	output logic slave_en_o, // Normal slave operation allowed
	output logic cfg_done_o, // Configuration complete
	input wire logic link_clk_i, // Bus front end clock
	input wire logic bus_cyc_i, // Cycle pulse, link clock
	input wire logic bus_iack_i, // Cycle is an acknowledge
	input wire logic bus_write_i, // Cycle is a write
	input wire logic [1:0] bus_am_i, // Modifier class
	input wire logic bus_a2_i, // Address line A2
	input wire logic [3:0] bus_region_i, // Region select inputs
	output logic bus_ack_o // Cycle accepted, link pulse
);

	vcl_state_t state;
	logic [15:0] cnt;
	logic [8:0] bit_cnt;
	logic [1:0] phase;
	vcl_am_t first_am;
	logic sense_clk_hi;
	logic sclk_drv;
	logic own_fall;
	logic fall_d;
	logic sclk_prev;
	logic [15:0] div_cnt;
	logic req_seen;
	logic ack_tgl;
	logic rej_tgl;

	// Link domain registers
	logic lnk_busy;
	logic lnk_req_tgl;
	logic lnk_ack_seen;
	logic lnk_rej_seen;
	logic lnk_iack;
	logic lnk_write;
	logic [1:0] lnk_am;
	logic lnk_a2;
	logic [3:0] lnk_region;
	logic lnk_ack;

	// Pins and the link request toggle entering the device clock domain
	logic [3:0] pin_sync;
	vcl_sync #(
		.W(4)
	) u_dev_sync (
		.clk_i(ref_clk_i),
		.d_i({lnk_req_tgl, sys_reset_n_i, serial_cfg_bit_in_i, sclk_in_i}),
		.q_o(pin_sync)
	);

	// Signals entering the link domain
	logic [2:0] lnk_sync;
	vcl_sync #(
		.W(3)
	) u_lnk_sync (
		.clk_i(link_clk_i),
		.d_i({rej_tgl, ack_tgl, nrst_i}),
		.q_o(lnk_sync)
	);

	wire req_tgl_s = pin_sync[3];
	wire sysrst_n_s = pin_sync[2];
	wire data_s = pin_sync[1];
	wire sclk_s = pin_sync[0];
	wire lnk_rst_n = lnk_sync[0];
	wire lnk_ack_tgl = lnk_sync[1];
	wire lnk_rej_tgl = lnk_sync[2];

	// Request decode in the device domain
	wire req_pend = req_tgl_s ^ req_seen;
	wire am_ok = (lnk_am == VCL_AM_A16) || (lnk_am == VCL_AM_CSR);
	wire reg_ok = (first_am == VCL_AM_CSR) ? ((lnk_region & `VCL_REGION_CSR_MASK) == 4'h0) :
		((lnk_region & `VCL_REGION_A16_MASK) == 4'h0);
	wire same_am = (lnk_am == first_am);
	wire first_wr = req_pend && lnk_write && !lnk_iack && am_ok;
	wire cfg_wr = req_pend && lnk_write && !lnk_iack && same_am && reg_ok;
	wire iack_req = req_pend && lnk_iack;
	wire cnt_zero = (cnt == 16'h0000);
	wire last_stream = (bit_cnt == `VCL_STREAM_BITS - 9'h001);

	// Falling serial clock, either source
	wire ext_fall = sclk_prev && !sclk_s;
	wire sclk_fall = sense_clk_hi ? own_fall : ext_fall;
	wire shifting = (state == VCL_ST_SER_SHIFT);

	// Answer now: serviced in a state or refused
	wire take_iack = (state == VCL_ST_BUS_IRQ) && iack_req;
	wire take_first = (state == VCL_ST_BUS_FIRST) && first_wr;
	wire take_bit = (state == VCL_ST_BUS_BITS) && cfg_wr;
	wire take_cmp = (state == VCL_ST_BUS_CMP) && cfg_wr;
	wire take_mask = (state == VCL_ST_BUS_MASK) && cfg_wr;
	wire take_any = take_iack || take_first || take_bit || take_cmp || take_mask;
	wire in_stb = (state == VCL_ST_BUS_FSTB) || (state == VCL_ST_BUS_CSTB) || (state == VCL_ST_BUS_MSTB);
	wire in_vec = (state == VCL_ST_BUS_VEC);
	wire finish = (in_stb || in_vec) && cnt_zero;
	wire refuse = req_pend && !take_any && !in_stb && !in_vec;

	// Main sequencer
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state <= VCL_ST_RESET;
			cnt <= `VCL_PROM_ENABLE_N_DLY_CLKS - 16'h0001;
			bit_cnt <= 9'h000;
			phase <= 2'h0;
			first_am <= VCL_AM_OTHER;
			sense_clk_hi <= 1'b0;
			prom_enable_n_o <= 1'b1;
			irq_n_o <= 1'b1;
			init_vector_enable_o <= 1'b0;
			local_data_enable_n_o <= 1'b1;
			compare_mask_select_o <= 1'b1;
			load_strobe_o <= 1'b0;
			cfg_done_o <= 1'b0;
		end else begin
			case (state)
				VCL_ST_RESET: begin
					if (cnt_zero) begin
						prom_enable_n_o <= 1'b0;
						cnt <= `VCL_SENSE_DLY_CLKS - 16'h0001;
						state <= VCL_ST_SENSE;
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				VCL_ST_SENSE: begin
					if (cnt_zero) begin
						sense_clk_hi <= sclk_s;
						cnt <= `VCL_SCLK_HALF_CLKS - 16'h0001;
						if (data_s) begin
							prom_enable_n_o <= 1'b1;
							state <= VCL_ST_BUS_WAIT;
						end else begin
							state <= VCL_ST_SER_SHIFT;
						end
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				VCL_ST_BUS_WAIT: begin
					if (sysrst_n_s) begin
						irq_n_o <= 1'b0;
						state <= VCL_ST_BUS_IRQ;
					end
				end
				VCL_ST_BUS_IRQ: begin
					if (take_iack) begin
						init_vector_enable_o <= 1'b1;
						irq_n_o <= 1'b1;
						cnt <= `VCL_VEC_CLKS - 16'h0001;
						state <= VCL_ST_BUS_VEC;
					end
				end
				VCL_ST_BUS_VEC: begin
					if (cnt_zero) begin
						init_vector_enable_o <= 1'b0;
						state <= VCL_ST_BUS_FIRST;
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				VCL_ST_BUS_FIRST: begin
					if (take_first) begin
						first_am <= vcl_am_t'(lnk_am);
						compare_mask_select_o <= 1'b1;
						load_strobe_o <= 1'b1;
						cnt <= `VCL_STROBE_CLKS - 16'h0001;
						state <= VCL_ST_BUS_FSTB;
					end
				end
				VCL_ST_BUS_BITS: begin
					if (take_bit) begin
						bit_cnt <= bit_cnt + 9'h001;
						if (last_stream) begin
							state <= VCL_ST_BUS_CMP;
						end
					end
				end
				VCL_ST_BUS_CMP, VCL_ST_BUS_MASK: begin
					if (take_cmp || take_mask) begin
						compare_mask_select_o <= take_cmp;
						load_strobe_o <= 1'b1;
						cnt <= `VCL_STROBE_CLKS - 16'h0001;
						state <= take_cmp ? VCL_ST_BUS_CSTB : VCL_ST_BUS_MSTB;
					end
				end
				VCL_ST_BUS_FSTB, VCL_ST_BUS_CSTB, VCL_ST_BUS_MSTB: begin
					if (cnt_zero) begin
						load_strobe_o <= 1'b0;
						if (state == VCL_ST_BUS_FSTB) begin
							state <= VCL_ST_BUS_BITS;
						end else if (state == VCL_ST_BUS_CSTB) begin
							state <= VCL_ST_BUS_MASK;
						end else begin
							cfg_done_o <= 1'b1;
							state <= VCL_ST_DONE;
						end
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				VCL_ST_SER_SHIFT: begin
					if (fall_d) begin
						bit_cnt <= bit_cnt + 9'h001;
						if (last_stream) begin
							prom_enable_n_o <= 1'b1;
							if (!data_s) begin
								local_data_enable_n_o <= 1'b0;
								compare_mask_select_o <= 1'b1;
								load_strobe_o <= 1'b0;
								phase <= 2'h0;
								cnt <= `VCL_STROBE_CLKS - 16'h0001;
								state <= VCL_ST_LOC_LOAD;
							end else begin
								state <= VCL_ST_BUS_WAIT;
							end
						end
					end
				end
				VCL_ST_LOC_LOAD: begin
					// Strobe low, high, low, high; select drops after first rise
					if (load_strobe_o && (phase == 2'h1) && (cnt == `VCL_STROBE_CLKS - 16'h0001)) begin
						compare_mask_select_o <= 1'b0;
					end
					if (cnt_zero) begin
						cnt <= `VCL_STROBE_CLKS - 16'h0001;
						phase <= phase + 2'h1;
						if (phase == 2'h3) begin
							load_strobe_o <= 1'b0;
							local_data_enable_n_o <= 1'b1;
							cfg_done_o <= 1'b1;
							state <= VCL_ST_DONE;
						end else begin
							load_strobe_o <= ~load_strobe_o;
						end
					end else begin
						cnt <= cnt - 16'h0001;
					end
				end
				default: begin
					state <= VCL_ST_DONE;
				end
			endcase
		end
	end

	// Own serial clock divider and falling-edge pulses
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			sclk_drv <= 1'b0;
			own_fall <= 1'b0;
			fall_d <= 1'b0;
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= sclk_s;
			fall_d <= shifting && sclk_fall;
			own_fall <= 1'b0;
			if (shifting && sense_clk_hi && (div_cnt == 16'h0000)) begin
				sclk_drv <= ~sclk_drv;
				own_fall <= sclk_drv;
			end
		end
	end

	// Separate half-period counter while shifting
	// Main sequencer holds cnt in shift state, so the divider count lives here
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || !shifting) begin
			div_cnt <= `VCL_SCLK_HALF_CLKS - 16'h0001;
		end else begin
			div_cnt <= (div_cnt == 16'h0000) ? `VCL_SCLK_HALF_CLKS - 16'h0001 : div_cnt - 16'h0001;
		end
	end

	// Stream bit output: serial sample or bus A2 bit
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			cfg_bit_o <= 1'b0;
			cfg_bit_valid_o <= 1'b0;
		end else begin
			cfg_bit_valid_o <= (shifting && fall_d) || take_bit;
			if (shifting && fall_d) begin
				cfg_bit_o <= data_s;
			end else if (take_bit) begin
				cfg_bit_o <= lnk_a2;
			end
		end
	end

	// Answer handshake back to the link domain
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			req_seen <= 1'b0;
			ack_tgl <= 1'b0;
			rej_tgl <= 1'b0;
		end else if (take_bit || finish || refuse) begin
			req_seen <= req_tgl_s;
			// Separate toggles, so the verdict never skews against its event
			if (refuse) begin
				rej_tgl <= ~rej_tgl;
			end else begin
				ack_tgl <= ~ack_tgl;
			end
		end
	end

	// Link domain: capture a cycle, hold it until answered
	always_ff @(posedge link_clk_i) begin
		if (!lnk_rst_n) begin
			lnk_busy <= 1'b0;
			lnk_req_tgl <= 1'b0;
			lnk_ack_seen <= 1'b0;
			lnk_rej_seen <= 1'b0;
			lnk_iack <= 1'b0;
			lnk_write <= 1'b0;
			lnk_am <= 2'h0;
			lnk_a2 <= 1'b0;
			lnk_region <= 4'h0;
			lnk_ack <= 1'b0;
		end else begin
			lnk_ack <= 1'b0;
			if (lnk_busy && ((lnk_ack_tgl != lnk_ack_seen) || (lnk_rej_tgl != lnk_rej_seen))) begin
				lnk_ack_seen <= lnk_ack_tgl;
				lnk_rej_seen <= lnk_rej_tgl;
				lnk_busy <= 1'b0;
				lnk_ack <= (lnk_ack_tgl != lnk_ack_seen);
			end else if (!lnk_busy && bus_cyc_i) begin
				lnk_iack <= bus_iack_i;
				lnk_write <= bus_write_i;
				lnk_am <= bus_am_i;
				lnk_a2 <= bus_a2_i;
				lnk_region <= bus_region_i;
				lnk_req_tgl <= ~lnk_req_tgl;
				lnk_busy <= 1'b1;
			end
		end
	end

	// Pin and status outputs
	assign sclk_out_o = sclk_drv;
	assign sclk_oe_n_o = !(sense_clk_hi && shifting);
	assign irq_level_o = cfg_done_o ? irq_level_cfg_i : `VCL_INIT_IRQ_LEVEL;
	assign multi_write_n_o = 1'b1;
	assign block_xfer_n_o = 1'b1;
	assign am_drive_en_o = cfg_done_o;
	assign slave_en_o = cfg_done_o && sysrst_n_s;
	assign bus_ack_o = lnk_ack;

endmodule

// ==== verification/vcl_loader_props.sv ====
`timescale 1ns/1ps

module vcl_loader_props
	import vcl_loader_pkg::*;
(
	input wire logic ref_clk_i, // Clock
	input wire logic nrst_i, // Reset
	input wire logic sys_reset_n_i, // Backplane reset
	input wire logic sclk_in_i, // Clock pin
	input wire logic sclk_out_o, // Driven clock
	input wire logic sclk_oe_n_o, // Clock drive
	input wire logic prom_enable_n_o, // PROM enable
	input wire logic irq_n_o, // Interrupt
	input wire logic [2:0] irq_level_o, // Level
	input wire logic init_vector_enable_o, // Vector enable
	input wire logic local_data_enable_n_o, // Latch enable
	input wire logic compare_mask_select_o, // Select
	input wire logic load_strobe_o, // Strobe
	input wire logic multi_write_n_o, // Multi write
	input wire logic block_xfer_n_o, // Block transfer
	input wire logic cfg_bit_valid_o, // Bit pulse
	input wire logic am_drive_en_o, // Modifier drive
	input wire logic slave_en_o, // Slave enable
	input wire logic cfg_done_o // Done
);
	logic [6:0] hi_cnt;
	logic [6:0] half_cnt;
	logic [8:0] bit_cnt;
	logic toggled;

	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// Strobe high time, clock half period and stream bits
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			hi_cnt <= 7'h00;
			half_cnt <= 7'h00;
			bit_cnt <= 9'h000;
			toggled <= 1'b0;
		end else begin
			hi_cnt <= load_strobe_o ? hi_cnt + 7'h01 : 7'h00;
			half_cnt <= $changed(sclk_out_o) ? 7'h00 : half_cnt + 7'h01;
			bit_cnt <= prom_enable_n_o ? 9'h000 : bit_cnt + 9'(cfg_bit_valid_o);
			toggled <= !sclk_oe_n_o && ($changed(sclk_out_o) || toggled);
		end
	end

	a_prom_delay: assert property ($rose(nrst_i) |-> ##[3:4] !prom_enable_n_o) else $error("enable timing");
	a_bus_pins: assert property (multi_write_n_o && block_xfer_n_o) else $error("pins low");
	a_init_level: assert property (!cfg_done_o |-> irq_level_o == 3'h2) else $error("level");
	a_no_slave: assert property (!cfg_done_o |-> !am_drive_en_o && !slave_en_o) else $error("early slave");
	a_strobe_width: assert property ($fell(load_strobe_o) |-> hi_cnt == 7'h28) else $error("strobe width");
	a_select_step: assert property ($rose(load_strobe_o) && compare_mask_select_o && !local_data_enable_n_o
		|=> !compare_mask_select_o) else $error("select");
	a_clock_half: assert property ($changed(sclk_out_o) && toggled && !sclk_oe_n_o && !prom_enable_n_o
		|-> half_cnt == 7'h27) else $error("half period");
	a_stream_len: assert property ($rose(prom_enable_n_o) && (bit_cnt != 9'h000 || cfg_bit_valid_o)
		|-> bit_cnt + 9'(cfg_bit_valid_o) == 9'h17C) else $error("bit count");
	a_irq_gate: assert property ($fell(irq_n_o) |-> $past(sys_reset_n_i, 2)) else $error("irq in reset");
	a_vec_time: assert property ($rose(init_vector_enable_o) |-> init_vector_enable_o[*8] ##1 !init_vector_enable_o)
		else $error("vector time");
	a_bit_take: assert property ($fell(sclk_in_i) && sclk_oe_n_o && !prom_enable_n_o |-> ##[2:6] cfg_bit_valid_o)
		else $error("bit take");
endmodule

bind vcl_loader vcl_loader_props u_props (.ref_clk_i, .nrst_i, .sys_reset_n_i, .sclk_in_i, .sclk_out_o, .sclk_oe_n_o,
	.prom_enable_n_o, .irq_n_o, .irq_level_o, .init_vector_enable_o, .local_data_enable_n_o, .compare_mask_select_o,
	.load_strobe_o, .multi_write_n_o, .block_xfer_n_o, .cfg_bit_valid_o, .am_drive_en_o, .slave_en_o, .cfg_done_o);

// ==== verification/vcl_prom_model.sv ====
`timescale 1ns/1ps

module vcl_prom_model #(
	parameter int HALF_NS = 60
) (
	input wire logic ref_clk_i, // Clock
	input wire logic en_n_i, // PROM enable
	input wire logic sclk_i, // Clock pin
	input wire logic fitted_i, // PROM present
	input wire logic ext_clk_i, // Source the clock
	input wire logic [379:0] bits_i, // Stream
	output logic data_o, // Data pin
	output logic ext_sclk_o // Sourced clock
);
	int rises = 0;
	logic junk = 1'b0;

	// Rising clock steps the stream, first rise keeps the leading bit
	always @(posedge sclk_i or posedge en_n_i) begin
		if (en_n_i)
			rises <= 0;
		else
			rises <= rises + 1;
	end

	// Changing level once the stream is used up
	always @(posedge ref_clk_i) junk <= ~junk;

	// Pull-up when absent or disabled
	assign data_o = (!fitted_i || en_n_i) ? 1'b1 : (rises > 380 ? junk : bits_i[(rises == 0) ? 0 : rises - 1]);

	// Clock starts low, waits past sensing, then 380 periods
	initial begin
		ext_sclk_o = 1'b0;
		forever begin
			@(negedge en_n_i);
			if (ext_clk_i) begin
				repeat (50) @(posedge ref_clk_i);
				repeat (760) #(HALF_NS) ext_sclk_o = ~ext_sclk_o;
			end
		end
	end
endmodule

// ==== verification/tb_vcl_loader.sv ====
`timescale 1ns/1ps
`include "vcl_loader_cfg.svh"

module tb_vcl_loader;
	logic ref_clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic sys_reset_n_i = 1'b0;
	logic [2:0] irq_level_cfg_i = 3'h0;
	logic bus_cyc_i = 1'b0;
	logic bus_iack_i = 1'b0;
	logic bus_write_i = 1'b0;
	logic [1:0] bus_am_i = 2'h0;
	logic bus_a2_i = 1'b0;
	logic [3:0] bus_region_i = 4'h0;
	logic ext = 1'b0;
	logic fitted = 1'b1;
	logic stb_q = 1'b0;
	logic vec_seen = 1'b0;
	logic [379:0] bits = '0;
	logic [1:0] am;
	logic [3:0] rg;
	int fails = 0;
	int checks_done = 0;
	int cyc = 0;
	int nbits = 0;
	int nstb = 0;
	int k;
	wire serial_cfg_bit_in_i;
	wire sclk_in_i;
	wire ext_sclk;
	wire sclk_out_o, sclk_oe_n_o, prom_enable_n_o, irq_n_o, init_vector_enable_o, local_data_enable_n_o;
	wire compare_mask_select_o, load_strobe_o, multi_write_n_o, block_xfer_n_o, cfg_bit_o, cfg_bit_valid_o;
	wire am_drive_en_o, slave_en_o, cfg_done_o, bus_ack_o;
	wire [2:0] irq_level_o;

	vcl_loader uut (.ref_clk_i, .nrst_i, .sys_reset_n_i, .serial_cfg_bit_in_i, .sclk_in_i, .sclk_out_o, .sclk_oe_n_o,
		.prom_enable_n_o, .irq_n_o, .irq_level_o, .irq_level_cfg_i, .init_vector_enable_o, .local_data_enable_n_o,
		.compare_mask_select_o, .load_strobe_o, .multi_write_n_o, .block_xfer_n_o, .cfg_bit_o, .cfg_bit_valid_o,
		.am_drive_en_o, .slave_en_o, .cfg_done_o, .link_clk_i, .bus_cyc_i, .bus_iack_i, .bus_write_i, .bus_am_i,
		.bus_a2_i, .bus_region_i, .bus_ack_o);
	vcl_prom_model #(.HALF_NS(60)) u_prom (.ref_clk_i, .en_n_i(prom_enable_n_o), .sclk_i(sclk_in_i), .fitted_i(fitted),
		.ext_clk_i(ext), .bits_i(bits), .data_o(serial_cfg_bit_in_i), .ext_sclk_o(ext_sclk));

	// Clock pin: device drive, else source or pull-up
	assign sclk_in_i = !sclk_oe_n_o ? sclk_out_o : (ext ? ext_sclk : 1'b1);

	// Clocks, link one offset in phase
	always #2.5 ref_clk_i = ~ref_clk_i;
	initial begin
		#7.3;
		forever #32 link_clk_i = ~link_clk_i;
	end

	// Timeout, stream bits, strobe pulses and vector enable, sampled settled
	always @(negedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			fails++;
			stop_test();
		end
		if (cfg_bit_valid_o === 1'b1) begin
			check(cfg_bit_o, bits[nbits]);
			nbits <= nbits + 1;
		end
		stb_q <= load_strobe_o;
		if (load_strobe_o === 1'b1 && !stb_q)
			nstb <= nstb + 1;
		if (init_vector_enable_o === 1'b1)
			vec_seen <= 1'b1;
	end

	task automatic check(input logic [8:0] seen, input logic [8:0] want);
		checks_done++;
		if (seen !== want) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic stop_test();
		if (fails == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic do_reset(input logic e, input logic f);
		nrst_i = 1'b0;
		ext = e;
		fitted = f;
		repeat (12) @(posedge ref_clk_i);
		repeat (3) @(posedge link_clk_i);
		@(posedge ref_clk_i);
		#1;
		nbits = 0;
		nstb = 0;
		vec_seen = 1'b0;
		nrst_i = 1'b1;
	endtask

	// One link cycle; want tells whether an acknowledge is due
	task automatic bus(input logic iack, input logic [1:0] a, input logic a2, input logic [3:0] r, input logic want);
		int n;
		@(posedge link_clk_i);
		#1;
		bus_cyc_i = 1'b1;
		bus_iack_i = iack;
		bus_write_i = !iack;
		bus_am_i = a;
		bus_a2_i = a2;
		bus_region_i = r;
		@(posedge link_clk_i);
		#1;
		bus_cyc_i = 1'b0;
		n = 0;
		while (bus_ack_o !== 1'b1 && n < 40) begin
			@(posedge link_clk_i);
			#1;
			n++;
		end
		check(9'(n < 40), 9'(want));
	endtask

	task automatic wait_done(input int lim);
		k = 0;
		while (cfg_done_o !== 1'b1 && k < lim) begin
			@(posedge ref_clk_i);
			k++;
		end
		repeat (3) @(posedge ref_clk_i);
		#1;
	endtask

	initial begin
		void'($urandom(32'h8d1a_248b));
		irq_level_cfg_i = 3'($urandom);
		for (k = 1; k < 379; k++)
			bits[k] = 1'($urandom);
		// Serial stream on the device clock, last bit zero
		do_reset(1'b0, 1'b1);
		repeat (60) @(posedge ref_clk_i);
		check(sclk_oe_n_o, 1'b0);
		wait_done(40000);
		check(nbits, 9'h17C);
		check(nstb, 9'h002);
		check({prom_enable_n_o, local_data_enable_n_o, irq_n_o, slave_en_o}, 4'hE);
		check(irq_level_o, irq_level_cfg_i);
		sys_reset_n_i = 1'b1;
		repeat (6) @(posedge ref_clk_i);
		check({slave_en_o, am_drive_en_o}, 2'h3);
		// Received clock, last bit one waits for backplane reset
		sys_reset_n_i = 1'b0;
		bits[379] = 1'b1;
		do_reset(1'b1, 1'b1);
		repeat (60) @(posedge ref_clk_i);
		check(sclk_oe_n_o, 1'b1);
		for (k = 0; k < 20000 && nbits < 380; k++)
			@(posedge ref_clk_i);
		repeat (30) @(posedge ref_clk_i);
		check({prom_enable_n_o, irq_n_o}, 2'h3);
		sys_reset_n_i = 1'b1;
		repeat (10) @(posedge ref_clk_i);
		check(irq_n_o, 1'b0);
		// Bus method, pin pulled high
		sys_reset_n_i = 1'b0;
		do_reset(1'b0, 1'b0);
		repeat (4) @(posedge link_clk_i);
		am = 2'h1 + 2'($urandom % 2);
		bus(1'b0, am, 1'b0, 4'h0, 1'b0);
		check({prom_enable_n_o, irq_n_o}, 2'h3);
		sys_reset_n_i = 1'b1;
		repeat (10) @(posedge ref_clk_i);
		check(irq_n_o, 1'b0);
		bus(1'b1, am, 1'b0, 4'($urandom), 1'b1);
		check(vec_seen, 1'b1);
		bus(1'b0, am, 1'b0, 4'($urandom), 1'b1);
		for (int i = 0; i < 382; i++) begin
			rg = 4'($urandom) & ~((am == 2'h2) ? `VCL_REGION_CSR_MASK : `VCL_REGION_A16_MASK);
			if (i < 380)
				bits[i] = 1'($urandom);
			if (i == 100)
				bus(1'b0, am, 1'b0, rg | 4'h1, 1'b0);
			if (i == 200)
				bus(1'b0, 2'h3 - am, 1'b0, rg, 1'b0);
			bus(1'b0, am, (i < 380) ? bits[i] : 1'b0, rg, 1'b1);
		end
		wait_done(2000);
		check(nstb, 9'h003);
		bus(1'b0, am, 1'b0, rg, 1'b0);
		stop_test();
	end
endmodule
